// ===== bench/spg_cell_model.sv
`timescale 1ns/1ps

module spg_cell_model
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic       chan_a_i,
  input  wire logic       data_sel_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      rdata_o,
  output logic            rts_a_o,
  output logic            rts_b_o,
  output int              gap_o
);
  logic [7:0] mem_q [4];
  logic [7:0] junk_q;
  int         cnt_q;

  // Cell always wants to send, so any forcing of RTS shows
  assign rts_a_o = 1'b1;
  assign rts_b_o = 1'b1;
  // Outside a strobe the bus toggles, so a late sample cannot pass
  assign rdata_o = stb_i ? mem_q[{chan_a_i, data_sel_i}] : junk_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q  <= 0;
      gap_o  <= 0;
      junk_q <= 8'hA5;
    end
    else
    begin
      junk_q <= ~junk_q;
      cnt_q  <= cnt_q + 1;
      if (stb_i)
      begin
        gap_o <= cnt_q;
        cnt_q <= 1;
        if (we_i)
          mem_q[{chan_a_i, data_sel_i}] <= wdata_i;
      end
    end
  end
endmodule

// ===== bench/spg_glue_regs_tb.sv
`timescale 1ns/1ps
`include "spg_regs.svh"

module spg_glue_regs_tb;
  localparam int LIM = 200;
  logic        clk_i = 1'b0, reset_n_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0, rxd_a_i = 1'b0, rxd_b_i = 1'b0;
  logic        port_general_line_b_i = 1'b0, txrx_clock_in_chan_b_i = 1'b0;
  logic [7:0]  cell_rdata_i, cell_wdata_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o, cell_rts_a_i, cell_rts_b_i;
  logic        cell_stb_o, cell_we_o, cell_chan_a_o, cell_data_sel_o;
  logic        request_to_send_chan_a_o, request_to_send_chan_b_o;
  logic        port_oe_n_a_o, port_oe_n_b_o, irq_o;
  logic        clear_to_send_chan_b_o, carrier_detect_chan_b_o;
  logic        dma_detect_a_o, dma_detect_b_o;
  int          gap, n, i, num_errors = 0, samples_checked = 0;
  logic [7:0]  ofs [8] = '{`SPG_RECOV_OFS, `SPG_ARM_A_OFS, `SPG_ARM_B_OFS,
                           `SPG_ROUTE_B_OFS, `SPG_DETECT_OFS,
                           `SPG_ROUTE_A_OFS, `SPG_IRQ_EN_OFS,
                           `SPG_IRQ_CLR_OFS};
  logic [7:0]  msk [8] = '{8'h3F, 8'h01, 8'h01, 8'h10, 8'h00, 8'h10, 8'h03,
                           8'h00};

  spg_glue_regs #(.BIT_CYCLES(4), .MARK_BITS(3)) i_spg_glue_regs
  (
    .clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .cell_stb_o, .cell_we_o,
    .cell_chan_a_o, .cell_data_sel_o, .cell_wdata_o, .cell_rdata_i,
    .cell_rts_a_i, .cell_rts_b_i, .rxd_a_i, .rxd_b_i, .port_general_line_b_i,
    .txrx_clock_in_chan_b_i, .request_to_send_chan_a_o,
    .request_to_send_chan_b_o, .port_oe_n_a_o, .port_oe_n_b_o,
    .clear_to_send_chan_b_o, .carrier_detect_chan_b_o, .dma_detect_a_o,
    .dma_detect_b_o, .irq_o
  );

  spg_cell_model i_spg_cell_model
  (
    .clk_i, .reset_n_i, .stb_i(cell_stb_o), .we_i(cell_we_o),
    .chan_a_i(cell_chan_a_o), .data_sel_i(cell_data_sel_o),
    .wdata_i(cell_wdata_o), .rdata_o(cell_rdata_i), .rts_a_o(cell_rts_a_i),
    .rts_b_o(cell_rts_b_i), .gap_o(gap)
  );

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(inout int c);
    @(posedge clk_i);
    c++;
    if (c > LIM)
    begin
      num_errors++;
      $display("BAD %0t: wait timed out", $time);
      final_report();
    end
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t: word %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t: bit %b expected %b", $time, g, e);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er = `SPG_RESP_OKAY);
    logic aw_ok, w_ok;
    int   c;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    c = 0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      tick(c);
      if (!aw_ok && s_axi_awready_o === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!w_ok && s_axi_wready_o === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    while (s_axi_bvalid_o !== 1'b1)
      tick(c);
    s_axi_bready_i <= 1'b0;
    chk_word({30'h0, s_axi_bresp_o}, {30'h0, er});
    @(posedge clk_i);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er = `SPG_RESP_OKAY);
    int c;
    c = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do
      tick(c);
    while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    while (s_axi_rvalid_o !== 1'b1)
      tick(c);
    s_axi_rready_i <= 1'b0;
    chk_word({30'h0, s_axi_rresp_o}, {30'h0, er});
    if (er == `SPG_RESP_OKAY)
      chk_word(s_axi_rdata_o, ed);
    @(posedge clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    for (i = 0; i < 8; i++)
    begin
      axi_read(ofs[i], 32'h0);
      axi_write(ofs[i], 32'hFFFF_FFFF);
      axi_read(ofs[i], {24'h0, msk[i]});
      axi_write(ofs[i], 32'h0);
    end
    // Lane 0 strobe off: the byte must not land
    s_axi_wstrb_i <= 4'hE;
    axi_write(`SPG_RECOV_OFS, 32'h3F);
    s_axi_wstrb_i <= 4'hF;
    axi_read(`SPG_RECOV_OFS, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      axi_write(`SPG_ROUTE_B_OFS, {27'h0, i[0], 4'h0});
      port_general_line_b_i <= 1'b1;
      txrx_clock_in_chan_b_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk_bit(clear_to_send_chan_b_o, i[0]);
      chk_bit(carrier_detect_chan_b_o, !i[0]);
      port_general_line_b_i <= 1'b0;
      txrx_clock_in_chan_b_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk_bit(clear_to_send_chan_b_o, !i[0]);
      chk_bit(carrier_detect_chan_b_o, 1'b0);
    end
    // A long count so the spacing clearly exceeds bus turnaround
    axi_write(`SPG_RECOV_OFS, 32'h14);
    for (i = 0; i < 4; i++)
      axi_write({2'b00, i[1:0], 4'h0}, 32'(17 * (i + 1)));
    chk_bit(gap >= 21, 1'b1);
    for (i = 0; i < 4; i++)
      axi_read({2'b00, i[1:0], 4'h0}, 32'(17 * (i + 1)));
    chk_bit(gap >= 21, 1'b1);
    axi_write(`SPG_RECOV_OFS, 32'h0);
    axi_write(`SPG_IRQ_EN_OFS, 32'h3);
    chk_bit(request_to_send_chan_a_o, 1'b1);
    axi_write(`SPG_ARM_A_OFS, 32'h1);
    chk_bit(request_to_send_chan_a_o, 1'b0);
    rxd_b_i <= 1'b1;
    // Runs of eight mark cycles stay below the twelve-cycle threshold
    for (i = 0; i < 6; i++)
    begin
      rxd_a_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rxd_a_i <= 1'b0;
      @(posedge clk_i);
    end
    axi_read(`SPG_DETECT_OFS, 32'h0);
    rxd_a_i <= 1'b1;
    n = 0;
    while (dma_detect_a_o !== 1'b1)
      tick(n);
    chk_bit(n >= 12, 1'b1);
    chk_bit(port_oe_n_a_o, 1'b1);
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b1);
    axi_read(`SPG_DETECT_OFS, 32'h2);
    axi_read(`SPG_IRQ_STS_OFS, 32'h1);
    axi_write(`SPG_IRQ_CLR_OFS, 32'h1);
    axi_read(`SPG_IRQ_STS_OFS, 32'h0);
    chk_bit(irq_o, 1'b0);
    rxd_a_i <= 1'b0;
    axi_read(`SPG_DETECT_OFS, 32'h2);
    axi_write(`SPG_ARM_A_OFS, 32'h0);
    axi_read(`SPG_DETECT_OFS, 32'h0);
    chk_bit(port_oe_n_a_o, 1'b0);
    chk_bit(request_to_send_chan_a_o, 1'b1);
    axi_write(`SPG_IRQ_EN_OFS, 32'h1);
    chk_bit(request_to_send_chan_b_o, 1'b1);
    axi_write(`SPG_ARM_B_OFS, 32'h1);
    chk_bit(request_to_send_chan_b_o, 1'b0);
    n = 0;
    while (dma_detect_b_o !== 1'b1)
      tick(n);
    chk_bit(port_oe_n_b_o, 1'b1);
    axi_read(`SPG_DETECT_OFS, 32'h1);
    axi_read(`SPG_IRQ_STS_OFS, 32'h2);
    chk_bit(irq_o, 1'b0);
    axi_write(`SPG_IRQ_EN_OFS, 32'h3);
    repeat (2) @(posedge clk_i);
    chk_bit(irq_o, 1'b1);
    axi_write(8'hF0, 32'h1, `SPG_RESP_SLVERR);
    axi_read(8'hF0, 32'h0, `SPG_RESP_SLVERR);
    reset_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    axi_read(`SPG_DETECT_OFS, 32'h0);
    chk_bit(port_oe_n_b_o, 1'b0);
    chk_bit(request_to_send_chan_b_o, 1'b1);
    final_report();
  end
endmodule

// ===== hdl/spg_glue_regs.sv
`timescale 1ns/1ps
`include "spg_regs.svh"

module spg_glue_regs
  import spg_pkg::*;
#(
  parameter int BIT_CYCLES = `SPG_BIT_CYCLES,
  parameter int MARK_BITS  = `SPG_MARK_BITS
)
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             cell_stb_o,
  output logic             cell_we_o,
  output logic             cell_chan_a_o,
  output logic             cell_data_sel_o,
  output logic [7:0]       cell_wdata_o,
  input  wire logic [7:0]  cell_rdata_i,
  input  wire logic        cell_rts_a_i,
  input  wire logic        cell_rts_b_i,
  input  wire logic        rxd_a_i,
  input  wire logic        rxd_b_i,
  input  wire logic        port_general_line_b_i,
  input  wire logic        txrx_clock_in_chan_b_i,
  output logic             request_to_send_chan_a_o,
  output logic             request_to_send_chan_b_o,
  output logic             port_oe_n_a_o,
  output logic             port_oe_n_b_o,
  output logic             clear_to_send_chan_b_o,
  output logic             carrier_detect_chan_b_o,
  output logic             dma_detect_a_o,
  output logic             dma_detect_b_o,
  output logic             irq_o
);

  if (BIT_CYCLES < 2 || BIT_CYCLES > 65535 || MARK_BITS < 1 ||
      MARK_BITS > 31)
  begin : g_check
    $error("spg_glue_regs: BIT_CYCLES or MARK_BITS out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers: rxd A, rxd B, general line, txrx clock

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end
    else
    begin
      sync1_q <= {txrx_clock_in_chan_b_i, port_general_line_b_i,
                  rxd_b_i, rxd_a_i};
      sync2_q <= sync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Abort detectors, index 0 is channel A, 1 is channel B

  logic [1:0] arm_q;
  logic [1:0] det_w;

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_det
    logic [15:0] bit_cnt_q;
    logic [15:0] bit_cnt_d;
    logic [4:0]  mark_cnt_q;
    logic [4:0]  mark_cnt_d;
    logic        flag_q;
    logic        flag_d;
    logic        hit;

    always_comb
    begin
      bit_cnt_d  = 16'h0000;
      mark_cnt_d = 5'h00;
      hit        = 1'b0;
      // Any space bit restarts the run of marks
      if (arm_q[ch] && sync2_q[ch] && !flag_q)
      begin
        if (bit_cnt_q == 16'(BIT_CYCLES - 1))
        begin
          mark_cnt_d = mark_cnt_q + 5'h01;
          hit        = (mark_cnt_q == 5'(MARK_BITS - 1));
        end
        else
        begin
          bit_cnt_d  = bit_cnt_q + 16'h0001;
          mark_cnt_d = mark_cnt_q;
        end
      end
      // Armed only; disarm releases the flag
      flag_d = arm_q[ch] ? (flag_q | hit) : 1'b0;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        bit_cnt_q  <= 16'h0000;
        mark_cnt_q <= 5'h00;
        flag_q     <= 1'b0;
      end
      else
      begin
        bit_cnt_q  <= bit_cnt_d;
        mark_cnt_q <= mark_cnt_d;
        flag_q     <= flag_d;
      end
    end

    assign det_w[ch] = flag_q;
  end

  //////////////////////////////////////////////////////////////////////
  // Register bus, cell access and recovery timer

  spg_state_type             state_q, state_d;
  logic                      aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic                      ar_have_q, ar_have_d, op_we_q, op_we_d;
  spg_addr_type              aw_addr_q, aw_addr_d, ar_addr_q, ar_addr_d;
  logic [7:0]                wbyte_q, wbyte_d;
  logic                      wlane_q, wlane_d;
  logic                      awready_q, awready_d, wready_q, wready_d;
  logic                      arready_q, arready_d;
  logic                      bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]                bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]               rdata_q, rdata_d;
  logic                      stb_q, stb_d, cwe_q, cwe_d;
  logic                      cha_q, cha_d, csel_q, csel_d;
  logic [7:0]                cwdata_q, cwdata_d;
  logic [`SPG_RECOV_W-1:0]   irc_q, irc_d, rec_q, rec_d;
  logic [1:0]                arm_d;
  logic                      route_a_q, route_a_d, route_b_q, route_b_d;
  logic [1:0]                sts_q, sts_d, en_q, en_d, clr;
  logic [1:0]                det_prev_q;
  spg_addr_type              sel_addr;
  logic                      sel_we, go, is_cell, mapped;
  logic [7:0]                local_rd;

  always_comb
  begin
    sel_we   = aw_have_q && w_have_q;
    sel_addr = sel_we ? aw_addr_q : ar_addr_q;
    go       = sel_we || ar_have_q;
    is_cell  = (sel_addr == `SPG_CMD_A_OFS) ||
               (sel_addr == `SPG_CMD_B_OFS) ||
               (sel_addr == `SPG_DATA_A_OFS) ||
               (sel_addr == `SPG_DATA_B_OFS);
    mapped   = 1'b1;
    local_rd = 8'h00;
    unique case (sel_addr)
      `SPG_ROUTE_A_OFS: local_rd[`SPG_ROUTE_BIT] = route_a_q;
      `SPG_ROUTE_B_OFS: local_rd[`SPG_ROUTE_BIT] = route_b_q;
      `SPG_RECOV_OFS:   local_rd[`SPG_RECOV_W-1:0] = irc_q;
      `SPG_ARM_A_OFS:   local_rd[`SPG_ARM_BIT] = arm_q[0];
      `SPG_ARM_B_OFS:   local_rd[`SPG_ARM_BIT] = arm_q[1];
      `SPG_DETECT_OFS:  local_rd[1:0] = {det_w[0], det_w[1]};
      `SPG_IRQ_STS_OFS: local_rd[1:0] = sts_q;
      `SPG_IRQ_EN_OFS:  local_rd[1:0] = en_q;
      `SPG_IRQ_CLR_OFS: local_rd = 8'h00;
      default:          mapped = is_cell;
    endcase
  end

  always_comb
  begin
    state_d   = state_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    ar_have_d = ar_have_q;
    aw_addr_d = aw_addr_q;
    ar_addr_d = ar_addr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    op_we_d   = op_we_q;
    bvalid_d  = bvalid_q;
    rvalid_d  = rvalid_q;
    bresp_d   = bresp_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    stb_d     = 1'b0;
    cwe_d     = cwe_q;
    cha_d     = cha_q;
    csel_d    = csel_q;
    cwdata_d  = cwdata_q;
    irc_d     = irc_q;
    arm_d     = arm_q;
    route_a_d = route_a_q;
    route_b_d = route_b_q;
    en_d      = en_q;
    clr       = 2'b00;
    // Down-counter reloads on each cell access
    if (stb_q)
      rec_d = irc_q;
    else if (rec_q != '0)
      rec_d = rec_q - `SPG_RECOV_W'(1);
    else
      rec_d = rec_q;

    if (s_axi_awvalid_i && awready_q)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = {s_axi_awaddr_i[7:2], 2'b00};
    end
    if (s_axi_wvalid_i && wready_q)
    begin
      w_have_d = 1'b1;
      wbyte_d  = s_axi_wdata_i[7:0];
      wlane_d  = s_axi_wstrb_i[0];
    end
    if (s_axi_arvalid_i && arready_q)
    begin
      ar_have_d = 1'b1;
      ar_addr_d = {s_axi_araddr_i[7:2], 2'b00};
    end

    unique case (state_q)
      ST_IDLE:
      begin
        if (go && is_cell)
        begin
          // Hold off until the recovery gap has run out
          if (rec_q == '0)
          begin
            stb_d    = 1'b1;
            cwe_d    = sel_we && wlane_q;
            cha_d    = (sel_addr == `SPG_CMD_A_OFS) ||
                       (sel_addr == `SPG_DATA_A_OFS);
            csel_d   = (sel_addr == `SPG_DATA_A_OFS) ||
                       (sel_addr == `SPG_DATA_B_OFS);
            cwdata_d = wbyte_q;
            op_we_d  = sel_we;
            state_d  = ST_CELL;
          end
        end
        else if (go)
        begin
          op_we_d = sel_we;
          if (sel_we && wlane_q)
          begin
            unique case (sel_addr)
              `SPG_ROUTE_A_OFS: route_a_d = wbyte_q[`SPG_ROUTE_BIT];
              `SPG_ROUTE_B_OFS: route_b_d = wbyte_q[`SPG_ROUTE_BIT];
              `SPG_RECOV_OFS:   irc_d = wbyte_q[`SPG_RECOV_W-1:0];
              `SPG_ARM_A_OFS:   arm_d[0] = wbyte_q[`SPG_ARM_BIT];
              `SPG_ARM_B_OFS:   arm_d[1] = wbyte_q[`SPG_ARM_BIT];
              `SPG_IRQ_EN_OFS:  en_d = wbyte_q[1:0];
              `SPG_IRQ_CLR_OFS: clr = wbyte_q[1:0];
              default:          clr = 2'b00;
            endcase
          end
          if (sel_we)
          begin
            bvalid_d = 1'b1;
            bresp_d  = mapped ? `SPG_RESP_OKAY : `SPG_RESP_SLVERR;
          end
          else
          begin
            rvalid_d = 1'b1;
            rresp_d  = mapped ? `SPG_RESP_OKAY : `SPG_RESP_SLVERR;
            rdata_d  = {24'h000000, local_rd};
          end
          state_d = ST_RESP;
        end
      end
      ST_CELL:
      begin
        // Cell read byte is sampled in the strobe cycle
        if (op_we_q)
        begin
          bvalid_d = 1'b1;
          bresp_d  = `SPG_RESP_OKAY;
        end
        else
        begin
          rvalid_d = 1'b1;
          rresp_d  = `SPG_RESP_OKAY;
          rdata_d  = {24'h000000, cell_rdata_i};
        end
        state_d = ST_RESP;
      end
      ST_RESP:
      begin
        if (bvalid_q && s_axi_bready_i)
        begin
          bvalid_d  = 1'b0;
          aw_have_d = 1'b0;
          w_have_d  = 1'b0;
          state_d   = ST_IDLE;
        end
        if (rvalid_q && s_axi_rready_i)
        begin
          rvalid_d  = 1'b0;
          ar_have_d = 1'b0;
          state_d   = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
    arready_d = !ar_have_d;
    // New detection wins over a clear in the same cycle
    sts_d = (sts_q & ~clr) | (det_w & ~det_prev_q);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q    <= ST_IDLE;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      ar_have_q  <= 1'b0;
      aw_addr_q  <= 8'h00;
      ar_addr_q  <= 8'h00;
      wbyte_q    <= 8'h00;
      wlane_q    <= 1'b0;
      op_we_q    <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      arready_q  <= 1'b0;
      bvalid_q   <= 1'b0;
      rvalid_q   <= 1'b0;
      bresp_q    <= 2'h0;
      rresp_q    <= 2'h0;
      rdata_q    <= 32'h00000000;
      stb_q      <= 1'b0;
      cwe_q      <= 1'b0;
      cha_q      <= 1'b0;
      csel_q     <= 1'b0;
      cwdata_q   <= 8'h00;
      irc_q      <= '0;
      rec_q      <= '0;
      arm_q      <= 2'h0;
      route_a_q  <= 1'b0;
      route_b_q  <= 1'b0;
      sts_q      <= 2'h0;
      en_q       <= 2'h0;
      det_prev_q <= 2'h0;
    end
    else
    begin
      state_q    <= state_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      ar_have_q  <= ar_have_d;
      aw_addr_q  <= aw_addr_d;
      ar_addr_q  <= ar_addr_d;
      wbyte_q    <= wbyte_d;
      wlane_q    <= wlane_d;
      op_we_q    <= op_we_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      arready_q  <= arready_d;
      bvalid_q   <= bvalid_d;
      rvalid_q   <= rvalid_d;
      bresp_q    <= bresp_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      stb_q      <= stb_d;
      cwe_q      <= cwe_d;
      cha_q      <= cha_d;
      csel_q     <= csel_d;
      cwdata_q   <= cwdata_d;
      irc_q      <= irc_d;
      rec_q      <= rec_d;
      arm_q      <= arm_d;
      route_a_q  <= route_a_d;
      route_b_q  <= route_b_d;
      sts_q      <= sts_d;
      en_q       <= en_d;
      det_prev_q <= det_w;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin side outputs, all registered

  logic rts_a_q, rts_b_q, oe_n_a_q, oe_n_b_q, cts_q, dcd_q;
  logic dma_a_q, dma_b_q, irq_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rts_a_q  <= 1'b0;
      rts_b_q  <= 1'b0;
      oe_n_a_q <= 1'b0;
      oe_n_b_q <= 1'b0;
      cts_q    <= 1'b0;
      dcd_q    <= 1'b0;
      dma_a_q  <= 1'b0;
      dma_b_q  <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      // Armed detector holds RTS inactive for the packet tail
      rts_a_q  <= arm_q[0] ? 1'b0 : cell_rts_a_i;
      rts_b_q  <= arm_q[1] ? 1'b0 : cell_rts_b_i;
      oe_n_a_q <= det_w[0];
      oe_n_b_q <= det_w[1];
      cts_q    <= route_b_q ? sync2_q[2] : sync2_q[3];
      dcd_q    <= route_b_q ? 1'b0 : sync2_q[2];
      dma_a_q  <= det_w[0];
      dma_b_q  <= det_w[1];
      irq_q    <= |(sts_q & en_q);
    end
  end

  assign s_axi_awready_o          = awready_q;
  assign s_axi_wready_o           = wready_q;
  assign s_axi_arready_o          = arready_q;
  assign s_axi_bvalid_o           = bvalid_q;
  assign s_axi_bresp_o            = bresp_q;
  assign s_axi_rvalid_o           = rvalid_q;
  assign s_axi_rresp_o            = rresp_q;
  assign s_axi_rdata_o            = rdata_q;
  assign cell_stb_o               = stb_q;
  assign cell_we_o                = cwe_q;
  assign cell_chan_a_o            = cha_q;
  assign cell_data_sel_o          = csel_q;
  assign cell_wdata_o             = cwdata_q;
  assign request_to_send_chan_a_o = rts_a_q;
  assign request_to_send_chan_b_o = rts_b_q;
  assign port_oe_n_a_o            = oe_n_a_q;
  assign port_oe_n_b_o            = oe_n_b_q;
  assign clear_to_send_chan_b_o   = cts_q;
  assign carrier_detect_chan_b_o  = dcd_q;
  assign dma_detect_a_o           = dma_a_q;
  assign dma_detect_b_o           = dma_b_q;
  assign irq_o                    = irq_q;

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_recov_gap: assert property (stb_d |-> rec_q == '0)
    else $error("cell access issued before recovery ran out");
  a_recov_load: assert property (
    cell_stb_o |=> rec_q == $past(irc_q))
    else $error("recovery counter not reloaded on access");
  a_arm_only: assert property ($rose(det_w[0]) |-> $past(arm_q[0]))
    else $error("detect A set while unarmed");
  a_flag_hold: assert property (det_w[1] && arm_q[1] |=> det_w[1])
    else $error("detect B dropped while armed");
  a_flag_drop: assert property (!arm_q[0] |=> !det_w[0])
    else $error("detect A held after disarm");
  a_port_off: assert property (
    det_w[0] |=> port_oe_n_a_o && dma_detect_a_o)
    else $error("port A not tristated on detect");
  a_rts_taken: assert property (
    arm_q[1] |=> !request_to_send_chan_b_o)
    else $error("RTS B not held while armed");
  // Reset qualifier: the release edge still shows reset-held outputs
  a_cts_line: assert property (
    reset_n_i && route_b_q |=> clear_to_send_chan_b_o == $past(sync2_q[2]))
    else $error("CTS B not taken from general line");
  a_cts_clock: assert property (
    reset_n_i && !route_b_q |=>
      clear_to_send_chan_b_o == $past(sync2_q[3]) &&
      carrier_detect_chan_b_o == $past(sync2_q[2]))
    else $error("CTS B or DCD B routed wrongly");
  a_dcd_ground: assert property (
    route_b_q |=> !carrier_detect_chan_b_o)
    else $error("DCD B not low with routing bit set");

  c_stall: cover property (state_q == ST_IDLE && go && is_cell && rec_q != '0);
  c_det_a: cover property ($rose(det_w[0]));
  c_irq:   cover property ($rose(irq_o));

endmodule

// ===== hdl/spg_pkg.sv
package spg_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_CELL = 3'b010,
    ST_RESP = 3'b100
  } spg_state_type;

  typedef logic [7:0] spg_addr_type;

endpackage

// ===== hdl/spg_regs.svh
`ifndef SPG_REGS_SVH
`define SPG_REGS_SVH

`define SPG_CMD_B_OFS     8'h00
`define SPG_DATA_B_OFS    8'h10
`define SPG_CMD_A_OFS     8'h20
`define SPG_DATA_A_OFS    8'h30
`define SPG_ROUTE_B_OFS   8'h40
`define SPG_ROUTE_A_OFS   8'h50
`define SPG_RECOV_OFS     8'h60
`define SPG_ARM_A_OFS     8'h70
`define SPG_ARM_B_OFS     8'h80
`define SPG_DETECT_OFS    8'h90
`define SPG_IRQ_STS_OFS   8'hA4
`define SPG_IRQ_EN_OFS    8'hA8
`define SPG_IRQ_CLR_OFS   8'hAC

`define SPG_ROUTE_BIT     4
`define SPG_ARM_BIT       0
`define SPG_DET_A_BIT     1
`define SPG_DET_B_BIT     0
`define SPG_RECOV_W       6

`define SPG_MARK_BITS     15
`define SPG_CLK_NS        8
`define SPG_BIT_NS        4340
`define SPG_BIT_CYCLES    (`SPG_BIT_NS / `SPG_CLK_NS)

`define SPG_RESP_OKAY     2'b00
`define SPG_RESP_SLVERR   2'b10

`endif
